// ===== bil_pkg.sv
// constants, register map and shared types of the boot image loader
package bil_pkg;
   localparam int CLK_PERIOD_PS = 8000;
   localparam int PULL_DELAY_NS = 15000;
   localparam int PULL_CYC = (PULL_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int LINK_EN_NS = 200;
   localparam int LINK_EN_CYC = (LINK_EN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SPI_HZ_REF = 2500000;
   localparam int CORE_HZ_REF = 400000000;
   localparam int SPI_DIV = CORE_HZ_REF / SPI_HZ_REF;
   localparam int SPI_HALF = SPI_DIV / 2;
   localparam int LINK_TX_HALF = 4;
   localparam int RAM_AW = 14;
   localparam int GPIO_W = 16;
   localparam logic [31:0] CRC_POLY = 32'hEDB88320;
   localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
   localparam logic [31:0] CRC_SKIP = 32'h0D15AB1E;
   localparam logic [31:0] NULL_CHANEND = 32'h0000FF02;
   localparam logic [7:0] SPI_READ_CMD = 8'h03;
   localparam logic [23:0] SPI_START_ADDR = 24'h000000;
   localparam logic [7:0] END_TOKEN = 8'h01;
   localparam logic [15:0] OTP_IMAGE_ADDR = 16'h0000;
   localparam logic [15:0] OTP_SEC_ADDR = 16'h07FF;
   localparam logic [31:0] SEC_RESET = 32'h00000000;
   localparam logic [RAM_AW-1:0] RAM_BASE = 14'h0000;
   // security word bit positions
   localparam int SEC_JTAG_DIS = 0;
   localparam int SEC_LINK_DIS = 1;
   localparam int SEC_SECURE_BOOT = 5;
   localparam int SEC_REDUNDANT = 7;
   localparam int SEC_LOCK_LO = 8;
   localparam int SEC_MASTER_LOCK = 12;
   localparam int SEC_JTAG_OTP_DIS = 13;
   localparam int SEC_GP_LO = 15;
   localparam int SEC_GP_HI = 21;
   // register offsets
   localparam logic [7:0] REG_SECURITY = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_CONTROL = 8'h08;
   localparam logic [7:0] REG_LENGTH = 8'h0C;
   localparam int CTRL_RESTART = 0;
   typedef enum logic [1:0] {SRC_SPI, SRC_LINK, SRC_OTP} bil_src_e;
   typedef enum logic [3:0] {ST_SEC_REQ, ST_SEC_WAIT, ST_PLL, ST_SELECT, ST_LINK_EN,
                             ST_LOAD, ST_ACK, ST_DONE, ST_FAIL} bil_state_e;
   typedef enum logic [2:0] {P_ACK, P_LEN, P_PROG, P_CRC, P_END, P_DONE} bil_phase_e;
   typedef struct packed {
      logic valid;
      logic ctrl;
      logic [7:0] data;
   } bil_tok_s;
endpackage

// ===== bil_loader.sv
// boot image loader: security load, source select, spi/link/otp fetch, crc check
//
// Functional notes
// - all pin output enables and pulls are off while reset is held; the code keeps link_pulldown_en on during reset.
// - after reset, wait the pull delay, enable pulls, latch pll ratio straps.
// - boot source comes from the two boot-source straps in normal operation.
// - secure-boot security bit forces boot from otp address zero.
// - image is length word, length program words, then crc word.
// - crc field equal to skip marker bypasses the crc check.
// - length and crc words arrive least significant byte first.
// - words go to ram from the lowest address; execution starts there.
// - reflected crc-32, preset all ones, residue inverted before compare.
// - spi boot enables the four spi pins as master at a divided clock.
// - spi boot sends read command with 24-bit zero address, then streams.
// - spi clock idles low, data sampled on the rising edge.
// - every spi byte shifts least significant bit first.
// - link boot enables the link about 200 ns after boot starts.
// - link enable drops pull-downs, drives outgoing wires low, watches inputs.
// - link boot allocates channel-end 0 then reads the acknowledge channel word.
// - after image and end token, send end token to ack, free, jump.
// - security word is loaded from otp before source selection.
// - security bits 0, 1, 7 block debug, block switch, enable redundant rows.
// - bits 8..11 lock otp sectors; bit 12 locks all otp programming.
// - bit 13 blocks debug otp access; upper bits are general fields.
// - reset asserts asynchronously; boot waits for pll lock after release.
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module bil_loader (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic pll_locked,
   input wire logic pll_ratio_strap_lo,
   input wire logic pll_ratio_strap_hi,
   input wire logic [1:0] boot_src_strap,
   output logic [1:0] pll_ratio_sel,
   output logic [bil_pkg::GPIO_W-1:0] gpio_pull_en,
   output logic otp_rd,
   output logic [15:0] otp_addr,
   input wire logic [31:0] otp_rdata,
   output logic spi_oe,
   output logic spi_cs_n,
   output logic spi_sclk,
   output logic spi_mosi,
   input wire logic spi_miso,
   output logic link_out_oe,
   output logic link_pulldown_en,
   output logic link_out_wire_a,
   output logic link_out_wire_b,
   input wire logic link_in_wire_a,
   input wire logic link_in_wire_b,
   output logic ram_we,
   output logic [bil_pkg::RAM_AW-1:0] ram_addr,
   output logic [31:0] ram_wdata,
   output logic exec_start,
   output logic [bil_pkg::RAM_AW-1:0] exec_addr,
   output logic chanend0_alloc,
   output logic debug_block,
   output logic switch_block,
   output logic otp_redundant_en,
   output logic [3:0] otp_sector_lock,
   output logic otp_prog_lock,
   output logic debug_otp_block
);
   bil_pkg::bil_state_e state;
   bil_pkg::bil_src_e src;
   bil_pkg::bil_src_e sel_src;
   bil_pkg::bil_phase_e phase;
   bil_pkg::bil_tok_s spi_tok;
   bil_pkg::bil_tok_s link_tok;
   bil_pkg::bil_tok_s otp_tok;
   bil_pkg::bil_tok_s cur_tok;
   logic [7:0] in_meta;
   logic [7:0] in_sync;
   logic [31:0] sec;
   logic [15:0] wait_cnt;
   logic link_en;
   logic otp_rd_d;
   logic [31:0] crc;
   logic [31:0] len;
   logic [31:0] word;
   logic [31:0] crc_field;
   logic [31:0] ack_chan;
   logic [31:0] widx;
   logic [1:0] bcnt;
   logic crc_ok;
   logic load_fail;
   logic restart;
   logic spi_act;
   logic [7:0] spi_div;
   logic [5:0] spi_bit;
   logic [31:0] spi_tx;
   logic [7:0] spi_rx;
   logic lk_b_d;
   logic [8:0] lk_sh;
   logic [3:0] lk_cnt;
   logic [44:0] tx_sh;
   logic [5:0] tx_cnt;
   logic [2:0] tx_div;
   logic tx_busy;
   logic tx_done;
   logic otp_act;
   logic otp_pend;
   logic otp_have;
   logic [1:0] otp_bsel;
   logic [31:0] otp_word;
   logic miso_s;
   logic lk_a_s;
   logic lk_b_s;
   logic lock_s;

   // reflected crc-32 update over one byte, bit 0 first
   function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
      logic [31:0] r;
      r = c ^ {24'h000000, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ bil_pkg::CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   // strap to source mapping; value 3 falls back to otp
   function automatic bil_pkg::bil_src_e strap_src(input logic [1:0] s);
      case (s)
         2'h0: strap_src = bil_pkg::SRC_SPI;
         2'h1: strap_src = bil_pkg::SRC_LINK;
         default: strap_src = bil_pkg::SRC_OTP;
      endcase
   endfunction

   // two-flop synchronisers for every pin input
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         in_meta <= 8'h00;
         in_sync <= 8'h00;
      end else begin
         in_meta <= {spi_miso, link_in_wire_a, link_in_wire_b, pll_locked,
                     pll_ratio_strap_hi, pll_ratio_strap_lo, boot_src_strap};
         in_sync <= in_meta;
      end
   end
   assign miso_s = in_sync[7];
   assign lk_a_s = in_sync[6];
   assign lk_b_s = in_sync[5];
   assign lock_s = in_sync[4];

   assign sel_src = sec[bil_pkg::SEC_SECURE_BOOT] ? bil_pkg::SRC_OTP : strap_src(in_sync[1:0]);
   assign crc_ok = (crc_field == bil_pkg::CRC_SKIP) || (crc_field == ~crc);
   assign restart = reg_wr && (reg_addr == bil_pkg::REG_CONTROL) && reg_wdata[bil_pkg::CTRL_RESTART];

   always_comb begin
      case (src)
         bil_pkg::SRC_SPI: cur_tok = spi_tok;
         bil_pkg::SRC_LINK: cur_tok = link_tok;
         default: cur_tok = otp_tok;
      endcase
   end

   // boot sequencer; async reset leaves every pin undriven with gpio pulls off and link pull-downs on
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= bil_pkg::ST_SEC_REQ;
         src <= bil_pkg::SRC_SPI;
         wait_cnt <= 16'h0000;
         gpio_pull_en <= '0;
         pll_ratio_sel <= 2'h0;
         link_en <= 1'b0;
         chanend0_alloc <= 1'b0;
         exec_start <= 1'b0;
         load_fail <= 1'b0;
      end else begin
         exec_start <= 1'b0;
         case (state)
            bil_pkg::ST_SEC_REQ: state <= bil_pkg::ST_SEC_WAIT;
            bil_pkg::ST_SEC_WAIT: if (otp_rd_d) begin
               state <= bil_pkg::ST_PLL;
            end
            bil_pkg::ST_PLL: if (lock_s) begin
               if (wait_cnt == 16'(bil_pkg::PULL_CYC - 1)) begin
                  wait_cnt <= 16'h0000;
                  gpio_pull_en <= '1;
                  pll_ratio_sel <= in_sync[3:2];
                  state <= bil_pkg::ST_SELECT;
               end else begin
                  wait_cnt <= wait_cnt + 16'h0001;
               end
            end
            bil_pkg::ST_SELECT: begin
               src <= sel_src;
               load_fail <= 1'b0;
               if (sel_src == bil_pkg::SRC_LINK) begin
                  chanend0_alloc <= 1'b1;
                  state <= bil_pkg::ST_LINK_EN;
               end else begin
                  state <= bil_pkg::ST_LOAD;
               end
            end
            bil_pkg::ST_LINK_EN: begin
               if (wait_cnt == 16'(bil_pkg::LINK_EN_CYC - 1)) begin
                  wait_cnt <= 16'h0000;
                  link_en <= 1'b1;
                  state <= bil_pkg::ST_LOAD;
               end else begin
                  wait_cnt <= wait_cnt + 16'h0001;
               end
            end
            bil_pkg::ST_LOAD: if (phase == bil_pkg::P_DONE) begin
               if (!crc_ok) begin
                  load_fail <= 1'b1;
                  chanend0_alloc <= 1'b0;
                  state <= bil_pkg::ST_FAIL;
               end else if (src == bil_pkg::SRC_LINK && ack_chan != bil_pkg::NULL_CHANEND) begin
                  state <= bil_pkg::ST_ACK;
               end else begin
                  chanend0_alloc <= 1'b0;
                  exec_start <= 1'b1;
                  state <= bil_pkg::ST_DONE;
               end
            end
            bil_pkg::ST_ACK: if (tx_done) begin
               chanend0_alloc <= 1'b0;
               exec_start <= 1'b1;
               state <= bil_pkg::ST_DONE;
            end
            bil_pkg::ST_DONE, bil_pkg::ST_FAIL: if (restart) begin
               link_en <= 1'b0;
               state <= bil_pkg::ST_SELECT;
            end
            default: state <= bil_pkg::ST_SEC_REQ;
         endcase
      end
   end

   assign exec_addr = bil_pkg::RAM_BASE;
   assign link_out_oe = link_en;
   assign link_pulldown_en = ~link_en;

   // security word: loaded once from otp; software may only touch the general field
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sec <= bil_pkg::SEC_RESET;
      end else if (state == bil_pkg::ST_SEC_WAIT && otp_rd_d) begin
         sec <= otp_rdata;
      end else if (reg_wr && reg_addr == bil_pkg::REG_SECURITY) begin
         sec[bil_pkg::SEC_GP_HI:bil_pkg::SEC_GP_LO] <=
            reg_wdata[bil_pkg::SEC_GP_HI:bil_pkg::SEC_GP_LO];
      end
   end
   assign debug_block = sec[bil_pkg::SEC_JTAG_DIS];
   assign switch_block = sec[bil_pkg::SEC_LINK_DIS];
   assign otp_redundant_en = sec[bil_pkg::SEC_REDUNDANT];
   assign otp_prog_lock = sec[bil_pkg::SEC_MASTER_LOCK];
   assign otp_sector_lock = sec[bil_pkg::SEC_LOCK_LO +: 4] | {4{otp_prog_lock}};
   assign debug_otp_block = sec[bil_pkg::SEC_JTAG_OTP_DIS];

   // image parser shared by all three sources
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phase <= bil_pkg::P_LEN;
         bcnt <= 2'h0;
         crc <= bil_pkg::CRC_INIT;
         len <= 32'h00000000;
         word <= 32'h00000000;
         crc_field <= 32'h00000000;
         ack_chan <= bil_pkg::NULL_CHANEND;
         widx <= 32'h00000000;
         ram_we <= 1'b0;
         ram_addr <= bil_pkg::RAM_BASE;
         ram_wdata <= 32'h00000000;
      end else if (state == bil_pkg::ST_SELECT) begin
         phase <= (sel_src == bil_pkg::SRC_LINK) ? bil_pkg::P_ACK : bil_pkg::P_LEN;
         bcnt <= 2'h0;
         crc <= bil_pkg::CRC_INIT;
         widx <= 32'h00000000;
         ram_we <= 1'b0;
      end else begin
         ram_we <= 1'b0;
         if (state == bil_pkg::ST_LOAD && cur_tok.valid) begin
            case (phase)
               bil_pkg::P_ACK: if (!cur_tok.ctrl) begin
                  ack_chan <= {cur_tok.data, ack_chan[31:8]};
                  bcnt <= bcnt + 2'h1;
                  if (bcnt == 2'h3) begin
                     phase <= bil_pkg::P_LEN;
                  end
               end
               bil_pkg::P_LEN: if (!cur_tok.ctrl) begin
                  len <= {cur_tok.data, len[31:8]};
                  crc <= crc_byte(crc, cur_tok.data);
                  bcnt <= bcnt + 2'h1;
                  if (bcnt == 2'h3) begin
                     phase <= ({cur_tok.data, len[31:8]} == 32'h00000000) ?
                              bil_pkg::P_CRC : bil_pkg::P_PROG;
                  end
               end
               bil_pkg::P_PROG: if (!cur_tok.ctrl) begin
                  word <= {cur_tok.data, word[31:8]};
                  crc <= crc_byte(crc, cur_tok.data);
                  bcnt <= bcnt + 2'h1;
                  if (bcnt == 2'h3) begin
                     ram_we <= 1'b1;
                     ram_addr <= bil_pkg::RAM_BASE + widx[bil_pkg::RAM_AW-1:0];
                     ram_wdata <= {cur_tok.data, word[31:8]};
                     widx <= widx + 32'h00000001;
                     if (widx + 32'h00000001 == len) begin
                        phase <= bil_pkg::P_CRC;
                     end
                  end
               end
               bil_pkg::P_CRC: if (!cur_tok.ctrl) begin
                  crc_field <= {cur_tok.data, crc_field[31:8]};
                  bcnt <= bcnt + 2'h1;
                  if (bcnt == 2'h3) begin
                     phase <= (src == bil_pkg::SRC_LINK) ? bil_pkg::P_END : bil_pkg::P_DONE;
                  end
               end
               bil_pkg::P_END: if (cur_tok.ctrl && cur_tok.data == bil_pkg::END_TOKEN) begin
                  phase <= bil_pkg::P_DONE;
               end
               default: phase <= bil_pkg::P_DONE;
            endcase
         end
      end
   end

   // spi master, mode 0, lsb first; first 32 bits are command and address
   assign spi_act = (state == bil_pkg::ST_LOAD) && (src == bil_pkg::SRC_SPI) &&
                    (phase != bil_pkg::P_DONE);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         spi_oe <= 1'b0;
         spi_cs_n <= 1'b1;
         spi_sclk <= 1'b0;
         spi_div <= 8'h00;
         spi_bit <= 6'h00;
         spi_tx <= 32'h00000000;
         spi_rx <= 8'h00;
         spi_tok <= '0;
      end else begin
         spi_tok.valid <= 1'b0;
         spi_oe <= spi_act;
         spi_cs_n <= ~spi_act;
         if (!spi_act) begin
            spi_sclk <= 1'b0;
            spi_div <= 8'h00;
            spi_bit <= 6'h00;
            spi_tx <= {bil_pkg::SPI_START_ADDR[7:0], bil_pkg::SPI_START_ADDR[15:8],
                       bil_pkg::SPI_START_ADDR[23:16], bil_pkg::SPI_READ_CMD};
         end else if (spi_div == 8'(bil_pkg::SPI_HALF - 1)) begin
            spi_div <= 8'h00;
            spi_sclk <= ~spi_sclk;
            if (!spi_sclk) begin
               // rising edge: sample; the flash drove its bit on the falling edge
               if (spi_bit[5]) begin
                  spi_rx <= {miso_s, spi_rx[7:1]};
                  if (spi_bit[2:0] == 3'h7) begin
                     spi_tok <= '{valid: 1'b1, ctrl: 1'b0, data: {miso_s, spi_rx[7:1]}};
                  end
               end
               spi_bit <= (spi_bit == 6'h27) ? 6'h20 : spi_bit + 6'h01;
            end else begin
               spi_tx <= spi_tx >> 1;
            end
         end else begin
            spi_div <= spi_div + 8'h01;
         end
      end
   end
   assign spi_mosi = spi_tx[0];

   // link receiver: wire b strobes, wire a carries 9-bit tokens, lsb first, bit 8 = control
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lk_b_d <= 1'b0;
         lk_sh <= 9'h000;
         lk_cnt <= 4'h0;
         link_tok <= '0;
      end else begin
         lk_b_d <= lk_b_s;
         link_tok.valid <= 1'b0;
         if (!link_en) begin
            lk_cnt <= 4'h0;
         end else if (lk_b_s && !lk_b_d) begin
            lk_sh <= {lk_a_s, lk_sh[8:1]};
            if (lk_cnt == 4'h8) begin
               lk_cnt <= 4'h0;
               link_tok <= '{valid: 1'b1, ctrl: lk_a_s, data: lk_sh[8:1]};
            end else begin
               lk_cnt <= lk_cnt + 4'h1;
            end
         end
      end
   end

   // link transmitter: four data tokens naming the channel, then the end token
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_sh <= '0;
         tx_cnt <= 6'h00;
         tx_div <= 3'h0;
         tx_busy <= 1'b0;
         tx_done <= 1'b0;
         link_out_wire_b <= 1'b0;
      end else if (state != bil_pkg::ST_ACK) begin
         tx_busy <= 1'b0;
         tx_done <= 1'b0;
         link_out_wire_b <= 1'b0;
         tx_sh <= '0;
      end else if (!tx_busy && !tx_done) begin
         tx_busy <= 1'b1;
         tx_cnt <= 6'h00;
         tx_div <= 3'h0;
         tx_sh <= {1'b1, bil_pkg::END_TOKEN, 1'b0, ack_chan[31:24], 1'b0, ack_chan[23:16],
                   1'b0, ack_chan[15:8], 1'b0, ack_chan[7:0]};
      end else if (tx_busy) begin
         if (tx_div == 3'(bil_pkg::LINK_TX_HALF - 1)) begin
            tx_div <= 3'h0;
            link_out_wire_b <= ~link_out_wire_b;
            if (link_out_wire_b) begin
               tx_sh <= tx_sh >> 1;
               tx_cnt <= tx_cnt + 6'h01;
               if (tx_cnt == 6'h2C) begin
                  tx_busy <= 1'b0;
                  tx_done <= 1'b1;
               end
            end
         end else begin
            tx_div <= tx_div + 3'h1;
         end
      end
   end
   assign link_out_wire_a = tx_sh[0];

   // otp reader: security word at power-up, then image words split into bytes
   assign otp_act = (state == bil_pkg::ST_LOAD) && (src == bil_pkg::SRC_OTP) &&
                    (phase != bil_pkg::P_DONE);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         otp_rd <= 1'b0;
         otp_rd_d <= 1'b0;
         otp_addr <= bil_pkg::OTP_SEC_ADDR;
         otp_pend <= 1'b0;
         otp_have <= 1'b0;
         otp_bsel <= 2'h0;
         otp_word <= 32'h00000000;
         otp_tok <= '0;
      end else begin
         otp_rd <= 1'b0;
         otp_rd_d <= otp_rd;
         otp_tok.valid <= 1'b0;
         if (state == bil_pkg::ST_SEC_REQ) begin
            otp_rd <= 1'b1;
            otp_addr <= bil_pkg::OTP_SEC_ADDR;
         end else if (!otp_act) begin
            otp_addr <= bil_pkg::OTP_IMAGE_ADDR;
            otp_pend <= 1'b0;
            otp_have <= 1'b0;
            otp_bsel <= 2'h0;
         end else if (otp_have) begin
            otp_tok <= '{valid: 1'b1, ctrl: 1'b0, data: otp_word[8*otp_bsel +: 8]};
            otp_bsel <= otp_bsel + 2'h1;
            if (otp_bsel == 2'h3) begin
               otp_have <= 1'b0;
               otp_addr <= otp_addr + 16'h0001;
            end
         end else if (otp_pend) begin
            if (otp_rd_d) begin
               otp_word <= otp_rdata;
               otp_have <= 1'b1;
               otp_pend <= 1'b0;
            end
         end else begin
            otp_rd <= 1'b1;
            otp_pend <= 1'b1;
         end
      end
   end

   // register read port, data one cycle after the strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         case (reg_addr)
            bil_pkg::REG_SECURITY: reg_rdata <= sec;
            bil_pkg::REG_STATUS: reg_rdata <= {14'h0000, link_en, spi_act, chanend0_alloc,
                                               crc_ok, load_fail, 1'b0, 1'(phase == bil_pkg::P_DONE),
                                               phase, src, 2'h0, state};
            bil_pkg::REG_LENGTH: reg_rdata <= widx;
            default: reg_rdata <= 32'h00000000;
         endcase
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end
endmodule

// ===== bil_asserts.sv
// port assertions for the boot image loader, bound to its top module
`timescale 1ns/1ps
module bil_asserts (
   input wire logic clk,
   input wire logic rst,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic [bil_pkg::GPIO_W-1:0] gpio_pull_en,
   input wire logic otp_rd,
   input wire logic [15:0] otp_addr,
   input wire logic spi_oe,
   input wire logic spi_cs_n,
   input wire logic spi_sclk,
   input wire logic link_out_oe,
   input wire logic link_pulldown_en,
   input wire logic link_out_wire_a,
   input wire logic link_out_wire_b,
   input wire logic exec_start,
   input wire logic [bil_pkg::RAM_AW-1:0] exec_addr,
   input wire logic [3:0] otp_sector_lock,
   input wire logic otp_prog_lock
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // saturating count of edges since reset release
   logic [11:0] cnt;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt <= 12'h000;
      end else if (cnt != 12'hFFF) begin
         cnt <= cnt + 12'h001;
      end
   end
   a_reset_quiet: assert property ($fell(rst) |-> !spi_oe && !link_out_oe && gpio_pull_en == '0)
      else $error("pins driven during reset");
   // two cycles of slack for where the designer starts the count
   a_pull_delay: assert property ($rose(gpio_pull_en[0]) |-> cnt >= bil_pkg::PULL_CYC - 2)
      else $error("pulls enabled too early");
   a_sec_first: assert property (cnt == 12'h001 |-> otp_rd && otp_addr == bil_pkg::OTP_SEC_ADDR)
      else $error("security word not fetched first");
   a_exec_home: assert property (exec_start |-> exec_addr == bil_pkg::RAM_BASE ##1 !exec_start)
      else $error("bad start address or long start pulse");
   a_sclk_idle: assert property (spi_cs_n |-> !spi_sclk)
      else $error("spi clock high while deselected");
   a_link_init: assert property ($rose(link_out_oe) |-> !link_pulldown_en && !link_out_wire_a && !link_out_wire_b)
      else $error("link enabled in a wrong state");
   a_rdata_answer: assert property (reg_rdata != 32'h0 |-> $past(reg_rd))
      else $error("read data outside its cycle");
   a_lock_all: assert property (otp_prog_lock |-> otp_sector_lock == 4'hF)
      else $error("master lock leaves a sector open");
   c_exec: cover property (exec_start);
   c_spi: cover property (!spi_cs_n);
   c_link: cover property ($rose(link_out_oe));
endmodule
bind bil_loader bil_asserts chk (.*);

// ===== bil_otp_model.sv
// otp memory model: read taken at an edge, word then stands until the next read
`timescale 1ns/1ps
module bil_otp_model (
   input wire logic clk,
   input wire logic otp_rd,
   input wire logic [15:0] otp_addr,
   output logic [31:0] otp_rdata
);
   logic [31:0] mem [0:2047];
   logic [15:0] addr_q = 16'h0000;
   always_ff @(posedge clk) begin
      if (otp_rd) begin
         addr_q <= otp_addr;
      end
   end
   // rows past the array give a pattern, not a stale word
   assign otp_rdata = (addr_q < 16'h0800) ? mem[addr_q[10:0]] : 32'hA5A5A5A5;
endmodule

// ===== tb_top.sv
// self-checking bench: otp, spi and link boot, crc cases, registers, security decode
`timescale 1ns/1ps
module tb_top;
   logic clk, rst = 1, reg_wr = 0, reg_rd = 0, pll_ratio_strap_lo = 1, pll_ratio_strap_hi = 0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, otp_rdata, ram_wdata, d;
   logic [1:0] boot_src_strap = 2'h2, pll_ratio_sel;
   logic [15:0] otp_addr, gpio_pull_en;
   logic otp_rd, spi_oe, spi_cs_n, spi_sclk, spi_mosi, link_out_oe, link_pulldown_en;
   logic link_out_wire_a, link_out_wire_b, ram_we, exec_start, chanend0_alloc, debug_block;
   logic switch_block, otp_redundant_en, otp_prog_lock, debug_otp_block;
   logic pll_locked = 1, spi_miso = 0, link_in_wire_a = 0, link_in_wire_b = 0;
   logic [13:0] ram_addr, exec_addr;
   logic [3:0] otp_sector_lock;
   logic [31:0] ram [0:3];
   int n_errors = 0, samples_checked = 0, cyc = 0, n_exec = 0;
   bil_loader dut (.*);
   bil_otp_model otp (.clk, .otp_rd, .otp_addr, .otp_rdata);
   initial begin
      clk = 0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (ram_we) ram[ram_addr[1:0]] = ram_wdata;
      if (exec_start) n_exec++;
      if (cyc == 60000) begin
         n_errors++;
         test_done();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge clk) reg_rd <= 0;
      @(posedge clk) d = reg_rdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
      @(posedge clk) reg_wr <= 0;
   endtask
   // image: length 2, two words, crc word, security row at the top
   task automatic boot(input logic [1:0] s, input logic [31:0] sec, input logic [31:0] crc);
      otp.mem[0] = 32'h2;
      otp.mem[1] = 32'h11223344;
      otp.mem[2] = 32'h8899AABB;
      otp.mem[3] = crc;
      otp.mem[2047] = sec;
      ram[0] = 32'h0;
      ram[1] = 32'h0;
      n_exec = 0;
      @(posedge clk) {rst, boot_src_strap} <= {1'b1, s};
      repeat (6) @(posedge clk);
      rst <= 0;
   endtask
   task automatic wait_exec();
      for (int i = 0; i < 3000 && n_exec == 0; i++) @(posedge clk);
   endtask
   function automatic logic [31:0] crc_img();
      logic [31:0] c;
      logic [95:0] s;
      c = bil_pkg::CRC_INIT;
      s = {32'h8899AABB, 32'h11223344, 32'h2};
      for (int i = 0; i < 96; i++) c = (c >> 1) ^ ((c[0] ^ s[i]) ? bil_pkg::CRC_POLY : 32'h0);
      return ~c;
   endfunction
   task automatic t_otp(input logic [31:0] crc, input int ok);
      boot(2'h2, 32'h0, crc);
      wait_exec();
      chk(n_exec, ok);
      chk(ram[0], 32'h11223344);
      chk(ram[1], 32'h8899AABB);
      chk({gpio_pull_en, 14'h0, pll_ratio_sel}, 32'hFFFF0001);
      $display("otp boot test done");
   endtask
   task automatic t_restart();
      rd(8'h04);
      chk(d[13], 1);
      otp.mem[3] = bil_pkg::CRC_SKIP;
      wr(8'h08, 32'h1);
      wait_exec();
      chk(n_exec, 1);
      $display("restart test done");
   endtask
   task automatic t_secure();
      boot(2'h0, 32'h000030A3, bil_pkg::CRC_SKIP);
      wait_exec();
      chk({n_exec[7:0], 7'h0, spi_oe}, 16'h0100);
      chk({debug_block, switch_block, otp_redundant_en, otp_sector_lock, otp_prog_lock,
           debug_otp_block}, 9'h1FF);
      rd(8'h00);
      chk(d, 32'h000030A3);
      wr(8'h00, 32'hFFFFFFFF);
      rd(8'h00);
      chk(d, 32'h003FB0A3);
      rd(8'h10);
      chk(d, 32'h0);
      $display("secure boot test done");
   endtask
   task automatic t_spi();
      logic [31:0] cap;
      boot(2'h0, 32'h0, 32'h0);
      for (int i = 0; i < 3000 && !spi_oe; i++) @(posedge clk);
      chk({spi_oe, spi_cs_n}, 2'b10);
      for (int k = 0; k < 32; k++) begin
         @(posedge spi_sclk) cap[k] = spi_mosi;
      end
      chk(cap, {bil_pkg::SPI_START_ADDR, bil_pkg::SPI_READ_CMD});
      $display("spi command test done");
   endtask
   task automatic t_link();
      boot(2'h1, 32'h0, 32'h0);
      for (int i = 0; i < 3000 && !link_out_oe; i++) @(posedge clk);
      chk({link_pulldown_en, link_out_wire_a, link_out_wire_b, chanend0_alloc}, 4'h1);
      $display("link enable test done");
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      t_otp(bil_pkg::CRC_SKIP, 1);
      t_otp(crc_img(), 1);
      t_otp(~crc_img(), 0);
      t_restart();
      t_secure();
      t_spi();
      t_link();
      test_done();
   end
endmodule
